// ===== spwm_pkg.sv
// Package for the standard pulse-width channel block: register map, fields, reset values.
// Assumes a 32-bit APB master and a 20 MHz system clock feeding every timer.
package spwm_pkg;
  // Byte addresses of the registers on the bus.
  localparam logic [7:0] A_CTRL_OFS  = 8'h00;
  localparam logic [7:0] A_DH_OFS    = 8'h04;
  localparam logic [7:0] A_DL_OFS    = 8'h08;
  localparam logic [7:0] B_CTRL_OFS  = 8'h0C;
  localparam logic [7:0] B_DH_OFS    = 8'h10;
  localparam logic [7:0] B_DL_OFS    = 8'h14;
  localparam logic [7:0] TSEL_OFS    = 8'h18;
  localparam logic [7:0] TCFG0_OFS   = 8'h1C;
  localparam int         TCFG_STEP   = 4;
  localparam int         N_TMR       = 3;
  // Channel control fields.
  localparam int         ON_BIT      = 7;
  localparam int         STATE_BIT   = 5;
  localparam int         POL_BIT     = 4;
  // Duty low register keeps its two bits at the top of the byte.
  localparam int         DL_LSB      = 6;
  // Timer select fields.
  localparam int         TSEL_A_LSB  = 0;
  localparam int         TSEL_B_LSB  = 2;
  localparam logic [1:0] TSEL_RSVD   = 2'h3;
  // Timer configuration fields.
  localparam int         TC_PS_LSB   = 8;
  localparam int         TC_ON_BIT   = 10;
  localparam int         TC_CNT_LSB  = 16;
  // Reset values.
  localparam logic [7:0] PR_RST      = 8'hFF;
  localparam logic [1:0] PS_RST      = 2'h0;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [1:0] LOW_PH_MAX  = 2'h3;
  // Every timer step takes four oscillator periods times the prescale value.
  localparam int         OSC_PER_NS  = 50;
  localparam logic [7:0] TICK_BASE   = 8'h04;

  typedef struct packed {
    logic       on;
    logic       pol;
    logic [9:0] duty;
  } spwm_chcfg_s;

  typedef struct packed {
    logic       on;
    logic [1:0] ps;
    logic [7:0] pr;
  } spwm_tcfg_s;
endpackage

// ===== spwm_top.sv
// Two standard pulse-width channels, three selectable timebases and their APB register file.
// Assumes an APB master on clk_i and that software routes the pins as outputs.
//
// Operation
// - With polarity 0 the idle pin level is low, with polarity 1 it is high.
// - A disabled channel holds its pin at the idle level and makes no pulses.
// - The period is (period limit + 1) times 4 times the oscillator period times the prescale.
// - On the step after the counter equals the period limit the counter returns to zero.
// - Each period restart drives the active level unless the duty value is zero.
// - Each period restart copies the written duty value into the compare register.
// - A latched pulse width longer than the period keeps the pin at the active level.
// - The duty value is 10 bits, high byte holds bits 9..2, low register bits 7:6 hold 1..0.
// - Duty writes are buffered and act only from the next period restart.
// - The 10-bit timebase is the 8-bit counter plus two prescaler or clock phase bits.
// - The pin stays active while the 10-bit timebase is below the duty value.
// - The duty ratio is the duty value over 4 times (period limit + 1).
// - Each channel picks one of three timers by its own 2-bit select field.
`timescale 1ns/100ps

// One timebase: prescaled step, 8-bit counter and 10-bit extended count.
module spwm_tmr (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire spwm_pkg::spwm_tcfg_s cfg_i,
  output logic [9:0]             tb_o,
  output logic [7:0]             cnt_o,
  output logic                   roll_o
);
  logic [7:0] pre_r;
  logic [7:0] cnt_r;
  logic [7:0] term;
  logic [7:0] low;
  logic       tick;

  // Prescale 1, 4, 16, 64 gives a step of 4, 16, 64, 256 clocks.
  assign term = 8'((spwm_pkg::TICK_BASE << {cfg_i.ps, 1'b0}) - 8'h01);
  assign tick = cfg_i.on && (pre_r == term);
  assign roll_o = tick && (cnt_r == cfg_i.pr);
  // Low bits are clock phase at 1:1, otherwise the top prescaler bits.
  assign low  = pre_r >> {cfg_i.ps, 1'b0};
  assign tb_o = {cnt_r, low[1:0]};
  assign cnt_o = cnt_r;

  // Prescaler runs only while the timer is on; a stopped timer holds it at zero, so its phase is lost.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pre_r <= spwm_pkg::BYTE_ZERO;
    end else if (tick || !cfg_i.on) begin
      pre_r <= spwm_pkg::BYTE_ZERO;
    end else begin
      pre_r <= pre_r + 8'h01;
    end
  end

  // Counter wraps to zero on the step after it meets the period limit.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_r <= spwm_pkg::BYTE_ZERO;
    end else if (roll_o) begin
      cnt_r <= spwm_pkg::BYTE_ZERO;
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_match;
    tick && (cnt_r == cfg_i.pr);
  endsequence
  AST_WRAP: assert property (s_match |=> cnt_r == spwm_pkg::BYTE_ZERO)
    else $error("Counter did not wrap after period match.");
  AST_STEP: assert property (cfg_i.on && !tick && $stable(cfg_i) |=> $stable(cnt_r))
    else $error("Counter moved between prescaled steps.");
  AST_LOW: assert property (cfg_i.ps == spwm_pkg::PS_RST |-> tb_o[1:0] == pre_r[1:0])
    else $error("Timebase low bits are not the clock phase at 1:1.");
endmodule

// One channel: buffered duty, compare, polarity and enable.
module spwm_chan (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire spwm_pkg::spwm_chcfg_s cfg_i,
  input  wire logic                  sel_ok_i,
  input  wire logic [9:0]            tb_i,
  input  wire logic                  roll_i,
  output logic                       pin_o
);
  logic [9:0] dc_act_r;
  logic       act_r;
  logic       pin_r;
  logic       roll;
  logic       match;
  logic       lvl;

  // A reserved select has no timebase, so the waveform simply freezes.
  assign roll  = sel_ok_i && roll_i;
  assign match = sel_ok_i && (tb_i == dc_act_r);
  assign pin_o = pin_r;
  // The level drops in the cycle of the match itself, so the pulse lasts duty timebase counts (quarter steps), not one more.
  assign lvl   = act_r && !match;

  // The compare value only changes at a restart, which keeps edits glitch free.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      dc_act_r <= 10'h000;
    end else if (roll) begin
      dc_act_r <= cfg_i.duty;
    end
  end

  // Restart sets the active level unless the duty is zero, equality with the duty clears it.
  // A duty beyond the period never matches, so the level is left as it was.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      act_r <= 1'b0;
    end else if (roll) begin
      act_r <= (cfg_i.duty != 10'h000);
    end else if (match) begin
      act_r <= 1'b0;
    end
  end

  // Pin is registered; disabled channels sit at the polarity level.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pin_r <= 1'b0;
    end else if (!cfg_i.on) begin
      pin_r <= cfg_i.pol;
    end else begin
      pin_r <= lvl ^ cfg_i.pol;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_restart;
    roll;
  endsequence
  sequence s_quiet;
    !roll && !match;
  endsequence
  AST_IDLE: assert property (!cfg_i.on |=> pin_r == $past(cfg_i.pol))
    else $error("Disabled channel left its idle level.");
  AST_POL: assert property (!cfg_i.on && !cfg_i.pol |=> !pin_r)
    else $error("Idle level high with polarity zero.");
  AST_LATCH: assert property (s_restart |=> dc_act_r == $past(cfg_i.duty))
    else $error("Duty not latched at restart.");
  AST_BUF: assert property (!roll |=> $stable(dc_act_r))
    else $error("Active duty changed outside a restart.");
  AST_SET: assert property (s_restart ##0 (cfg_i.duty != 10'h000) |=> act_r)
    else $error("Restart did not set the active level.");
  AST_ZERO: assert property (s_restart ##0 (cfg_i.duty == 10'h000) |=> !act_r)
    else $error("Zero duty set the active level.");
  AST_CLR: assert property (match && !roll |=> !act_r && pin_r == $past(cfg_i.pol))
    else $error("Duty match did not end the pulse.");
  AST_HOLD: assert property (s_quiet |=> act_r == $past(act_r))
    else $error("Level changed with no restart and no match.");
endmodule

// Top: APB slave, register file, three timers and two channels.
module spwm_top (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             waveform_a_o,
  output logic             waveform_b_o
);
  spwm_pkg::spwm_chcfg_s ch_r [2];
  spwm_pkg::spwm_tcfg_s  tc_r [spwm_pkg::N_TMR];
  logic [1:0]            tsel_r [2];
  logic [9:0]            tb   [spwm_pkg::N_TMR];
  logic [7:0]            cnt  [spwm_pkg::N_TMR];
  logic [spwm_pkg::N_TMR-1:0] roll;
  logic [1:0]            pin;
  logic [31:0]           rd_data;
  logic                  hit;
  logic                  acc;
  logic                  wr;
  logic [31:0]           prdata_r;
  logic                  pready_r;
  logic                  pslverr_r;

  // One wait state: pready rises on the second access cycle.
  assign acc = psel_i && penable_i;
  assign wr  = acc && pready_r && pwrite_i && hit;

  // Timebases, one per selectable timer.
  for (genvar t = 0; t < spwm_pkg::N_TMR; t++) begin : g_tmr
    spwm_tmr u_tmr (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .cfg_i    (tc_r[t]),
      .tb_o     (tb[t]),
      .cnt_o    (cnt[t]),
      .roll_o   (roll[t])
    );
  end

  // Channels, each routed to the timer its select field names.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    spwm_chan u_ch (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .cfg_i    (ch_r[c]),
      .sel_ok_i (tsel_r[c] != spwm_pkg::TSEL_RSVD),
      .tb_i     (tb[tsel_r[c] == spwm_pkg::TSEL_RSVD ? 2'h0 : tsel_r[c]]),
      .roll_i   (roll[tsel_r[c] == spwm_pkg::TSEL_RSVD ? 2'h0 : tsel_r[c]]),
      .pin_o    (pin[c])
    );
  end
  assign waveform_a_o = pin[0];
  assign waveform_b_o = pin[1];

  // Read decode; unmapped addresses answer zero with an error.
  always_comb begin
    rd_data = 32'h0000_0000;
    hit     = 1'b1;
    unique case (paddr_i)
      spwm_pkg::A_CTRL_OFS, spwm_pkg::B_CTRL_OFS: begin
        rd_data[spwm_pkg::ON_BIT]    = ch_r[paddr_i == spwm_pkg::B_CTRL_OFS].on;
        rd_data[spwm_pkg::POL_BIT]   = ch_r[paddr_i == spwm_pkg::B_CTRL_OFS].pol;
        rd_data[spwm_pkg::STATE_BIT] = pin[paddr_i == spwm_pkg::B_CTRL_OFS];
      end
      spwm_pkg::A_DH_OFS: rd_data[7:0] = ch_r[0].duty[9:2];
      spwm_pkg::B_DH_OFS: rd_data[7:0] = ch_r[1].duty[9:2];
      spwm_pkg::A_DL_OFS: rd_data[spwm_pkg::DL_LSB +: 2] = ch_r[0].duty[1:0];
      spwm_pkg::B_DL_OFS: rd_data[spwm_pkg::DL_LSB +: 2] = ch_r[1].duty[1:0];
      spwm_pkg::TSEL_OFS: begin
        rd_data[spwm_pkg::TSEL_A_LSB +: 2] = tsel_r[0];
        rd_data[spwm_pkg::TSEL_B_LSB +: 2] = tsel_r[1];
      end
      default: begin
        hit = 1'b0;
        for (int t = 0; t < spwm_pkg::N_TMR; t++) begin
          if (paddr_i == 8'(spwm_pkg::TCFG0_OFS + t * spwm_pkg::TCFG_STEP)) begin
            hit = 1'b1;
            rd_data[10:0] = tc_r[t];
            rd_data[spwm_pkg::TC_CNT_LSB +: 8] = cnt[t];
          end
        end
      end
    endcase
  end

  // Bus handshake and read data are registered.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc && !pready_r;
      prdata_r  <= (acc && !pready_r && !pwrite_i) ? rd_data : 32'h0000_0000;
      pslverr_r <= acc && !pready_r && !hit;
    end
  end
  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;

  // Channel control and duty registers; duty bytes land in the shadow only.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < 2; c++) begin
        ch_r[c] <= '0;
      end
    end else if (wr) begin
      for (int c = 0; c < 2; c++) begin
        if (paddr_i == (c == 0 ? spwm_pkg::A_CTRL_OFS : spwm_pkg::B_CTRL_OFS)) begin
          ch_r[c].on  <= pwdata_i[spwm_pkg::ON_BIT];
          ch_r[c].pol <= pwdata_i[spwm_pkg::POL_BIT];
        end
        if (paddr_i == (c == 0 ? spwm_pkg::A_DH_OFS : spwm_pkg::B_DH_OFS)) begin
          ch_r[c].duty[9:2] <= pwdata_i[7:0];
        end
        if (paddr_i == (c == 0 ? spwm_pkg::A_DL_OFS : spwm_pkg::B_DL_OFS)) begin
          ch_r[c].duty[1:0] <= pwdata_i[spwm_pkg::DL_LSB +: 2];
        end
      end
    end
  end

  // Timer select and timer configuration registers.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tsel_r[0] <= 2'h0;
      tsel_r[1] <= 2'h0;
      for (int t = 0; t < spwm_pkg::N_TMR; t++) begin
        tc_r[t] <= '{on: 1'b0, ps: spwm_pkg::PS_RST, pr: spwm_pkg::PR_RST};
      end
    end else if (wr) begin
      if (paddr_i == spwm_pkg::TSEL_OFS) begin
        tsel_r[0] <= pwdata_i[spwm_pkg::TSEL_A_LSB +: 2];
        tsel_r[1] <= pwdata_i[spwm_pkg::TSEL_B_LSB +: 2];
      end
      for (int t = 0; t < spwm_pkg::N_TMR; t++) begin
        if (paddr_i == 8'(spwm_pkg::TCFG0_OFS + t * spwm_pkg::TCFG_STEP)) begin
          tc_r[t].pr <= pwdata_i[7:0];
          tc_r[t].ps <= pwdata_i[spwm_pkg::TC_PS_LSB +: 2];
          tc_r[t].on <= pwdata_i[spwm_pkg::TC_ON_BIT];
        end
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_RDY: assert property (acc && !pready_r |=> pready_r ##1 !pready_r)
    else $error("Access phase not answered after one wait state.");
  AST_STATE: assert property (acc && !pready_r && !pwrite_i && paddr_i == spwm_pkg::A_CTRL_OFS
                              |=> prdata_r[spwm_pkg::STATE_BIT] == $past(pin[0]))
    else $error("Output state bit does not show the pin.");
endmodule

// ===== spwm_load.sv
// Load model for one waveform pin: measures period, active time and pulse count.
// Assumes the pin is sampled on the rising edge of the bench clock and is always driven.
`timescale 1ns/100ps

module spwm_load (
  input  wire logic   clk_i,
  input  wire logic   resetn_i,
  input  wire logic   pin_i,
  output logic [15:0] per_o,
  output logic [15:0] hi_o,
  output logic [15:0] rises_o
);
  logic        prev_r;
  logic [15:0] cnt_r;
  logic [15:0] hi_r;

  // The pin is seen as a driven output, since software has set its direction.
  // A rise starts a new period; a fall freezes the active count of the pulse just seen.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      prev_r  <= 1'b0;
      cnt_r   <= 16'h0000;
      hi_r    <= 16'h0000;
      per_o   <= 16'h0000;
      hi_o    <= 16'h0000;
      rises_o <= 16'h0000;
    end else begin
      prev_r <= pin_i;
      if (pin_i && !prev_r) begin
        per_o   <= cnt_r;
        rises_o <= rises_o + 16'h0001;
        cnt_r   <= 16'h0001;
        hi_r    <= 16'h0001;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
        hi_r  <= hi_r + {15'h0000, pin_i};
      end
      if (!pin_i && prev_r) begin
        hi_o <= hi_r;
      end
    end
  end
endmodule

// ===== tb_spwm_top.sv
// Self-checking bench for the two-channel pulse-width block over APB.
// Assumes the block's own timers; pins are measured by two load models.
`timescale 1ns/100ps

module tb_spwm_top;
  logic        clk_i, resetn_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, waveform_a_o, waveform_b_o, err;
  logic [15:0] per_a, hi_a, rise_a, per_b, hi_b, rise_b, snap;
  int          fails, checks_done, mult;

  // Free-running 20 MHz clock.
  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  spwm_top u_spwm_top (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .waveform_a_o(waveform_a_o), .waveform_b_o(waveform_b_o));
  spwm_load u_spwm_load_a (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(waveform_a_o),
    .per_o(per_a), .hi_o(hi_a), .rises_o(rise_a));
  spwm_load u_spwm_load_b (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(waveform_b_o),
    .per_o(per_b), .hi_o(hi_b), .rises_o(rise_b));

  task automatic end_of_test();
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; an idle cycle always separates two calls, so no signal is set twice.
  // Signals change just after a rising edge; pready and data are taken as that edge sampled them.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  // Waits for k more pulses on one pin, under a bounded count.
  task automatic wait_rises(input int ch, input int k);
    int n;
    logic [15:0] s;
    @(negedge clk_i);
    s = ch ? rise_b : rise_a;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (int'((ch ? rise_b : rise_a) - s) < k && n < 5000);
    if (n >= 5000) fails++;
  endtask

  function automatic logic [7:0] tcfg(input int t);
    return 8'(int'(spwm_pkg::TCFG0_OFS) + t * spwm_pkg::TCFG_STEP);
  endfunction

  // Watchdog sized well above the longest prescaled periods in the sequence.
  initial begin
    #2000000;
    fails++;
    end_of_test();
  end

  initial begin
    fails = 0;
    checks_done = 0;
    resetn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h00000000;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdchk(spwm_pkg::A_CTRL_OFS, 32'h00000000);
    rdchk(tcfg(0), 32'h000000FF);
    rdchk(spwm_pkg::TSEL_OFS, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
    // Idle level follows polarity; reserved control bits read back as zero.
    apb(1'b1, spwm_pkg::A_CTRL_OFS, 32'h0000007F);
    repeat (4) @(negedge clk_i);
    check({31'h0, waveform_a_o}, 32'h00000001);
    rdchk(spwm_pkg::A_CTRL_OFS, 32'h00000030);
    apb(1'b1, spwm_pkg::A_CTRL_OFS, 32'h00000000);
    repeat (4) @(negedge clk_i);
    check({31'h0, waveform_a_o}, 32'h00000000);
    // Duty 6 split over the high byte and the top two bits of the low register.
    apb(1'b1, spwm_pkg::A_DH_OFS, 32'h00000001);
    apb(1'b1, spwm_pkg::A_DL_OFS, 32'h00000080);
    rdchk(spwm_pkg::A_DL_OFS, 32'h00000080);
    apb(1'b1, spwm_pkg::A_CTRL_OFS, 32'h00000080);
    // Each timer in turn, with its own period limit, drives channel A.
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, tcfg(t), 32'h00000400 | (3 + t));
      apb(1'b1, spwm_pkg::TSEL_OFS, t);
      wait_rises(0, 3);
      check({16'h0, per_a}, 4 * (4 + t));
      check({16'h0, hi_a}, 32'h00000006);
    end
    // Every prescale code stretches period and pulse alike.
    apb(1'b1, spwm_pkg::TSEL_OFS, 32'h00000000);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, tcfg(0), 32'h00000403 | (c << 8));
      mult = 1 << (2 * c);
      wait_rises(0, 3);
      check({16'h0, per_a}, 16 * mult);
      check({16'h0, hi_a}, 6 * mult);
    end
    // A duty write in mid-pulse only acts from the next restart.
    apb(1'b1, tcfg(0), 32'h00000503);
    wait_rises(0, 3);
    wait_rises(0, 1);
    apb(1'b1, spwm_pkg::A_DH_OFS, 32'h00000002);
    wait_rises(0, 1);
    check({16'h0, hi_a}, 32'h00000018);
    wait_rises(0, 2);
    check({16'h0, hi_a}, 32'h00000028);
    // Duty zero never sets the pin.
    apb(1'b1, spwm_pkg::A_DH_OFS, 32'h00000000);
    apb(1'b1, spwm_pkg::A_DL_OFS, 32'h00000000);
    repeat (160) @(negedge clk_i);
    snap = rise_a;
    repeat (130) @(negedge clk_i);
    check({16'h0, rise_a}, {16'h0, snap});
    check({31'h0, waveform_a_o}, 32'h00000000);
    // A pulse width beyond the period leaves the pin set.
    apb(1'b1, spwm_pkg::A_DH_OFS, 32'h000000FF);
    apb(1'b1, spwm_pkg::A_DL_OFS, 32'h000000C0);
    repeat (160) @(negedge clk_i);
    snap = rise_a;
    repeat (130) @(negedge clk_i);
    check({16'h0, rise_a}, {16'h0, snap});
    check({31'h0, waveform_a_o}, 32'h00000001);
    // Disabling a running channel drops it to idle at once.
    apb(1'b1, spwm_pkg::A_CTRL_OFS, 32'h00000000);
    repeat (6) @(negedge clk_i);
    check({31'h0, waveform_a_o}, 32'h00000000);
    // Channel B on the second timer, then frozen by the reserved code.
    apb(1'b1, spwm_pkg::B_DL_OFS, 32'h00000080);
    apb(1'b1, spwm_pkg::TSEL_OFS, 32'h00000004);
    apb(1'b1, spwm_pkg::B_CTRL_OFS, 32'h00000080);
    wait_rises(1, 3);
    check({16'h0, per_b}, 32'h00000014);
    check({16'h0, hi_b}, 32'h00000002);
    apb(1'b1, spwm_pkg::TSEL_OFS, 32'h0000000C);
    repeat (10) @(negedge clk_i);
    snap = rise_b;
    repeat (60) @(negedge clk_i);
    check({16'h0, rise_b}, {16'h0, snap});
    end_of_test();
  end
endmodule
